// file: hw/flash_ctrl_defs.svh
// register offsets, field positions, reset values and timing counts for the flash controller
`ifndef FLASH_CTRL_DEFS_SVH
`define FLASH_CTRL_DEFS_SVH
`define OFS_STORE_CTRL 12'h000
`define OFS_FLASH_KEY 12'h004
`define OFS_PREFETCH_CTRL 12'h008
`define OFS_XDATA_WRITE 12'h00C
`define OFS_FLASH_DATA 12'h010
`define BIT_WRITE_EN 0
`define BIT_ERASE_EN 1
`define BIT_BLOCK_SEL 0
`define KEY_FIRST 8'hA5
`define KEY_SECOND 8'hF1
`define ERASED_BYTE 8'hFF
`define RESET_CTRL 8'h00
`define PAGE_BYTES 512
`define FLASH_BYTES 8192
`define PROG_TIME_NS 40
`define ERASE_TIME_NS 400
`define CLK_PERIOD_NS 5
`define PROG_CYCLES ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERASE_CYCLES ((`ERASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// file: hw/flash_ctrl_pkg.sv
// types shared by the flash write and erase controller
package flash_ctrl_pkg;
  typedef enum logic [1:0] {
    KEY_LOCKED = 2'b00,
    KEY_FIRST_OK = 2'b01,
    KEY_OPEN = 2'b10,
    KEY_DEAD = 2'b11
  } lock_state_t;
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_PROG = 3'b010,
    SEQ_ERASE = 3'b100
  } seq_state_t;
  typedef struct packed {
    logic [12:0] addr;
    logic [7:0] data;
    logic erase;
    logic pair;
  } flash_op_t;
endpackage : flash_ctrl_pkg

// file: hw/flash_array.sv
// flash cell array: programming only clears bits, page erase sets them
`timescale 1ns/100ps
`include "flash_ctrl_defs.svh"
module flash_array
  import flash_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic op_go,
  input wire flash_op_t op,
  input wire logic [7:0] even_data,
  input wire logic [12:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] cell_ff [0:`FLASH_BYTES-1];
  logic [12:0] even_addr;
  assign even_addr = {op.addr[12:1], 1'b0};

  // --------------------------------
  // cell updates
  // --------------------------------
  // no reset: flash contents are non-volatile
  always_ff @(posedge clk) begin
    if (op_go) begin
      if (op.erase) begin
        for (int i = 0; i < `PAGE_BYTES; i++) begin
          cell_ff[{op.addr[12:9], 9'(i)}] <= `ERASED_BYTE;
        end
      end else if (op.pair) begin
        cell_ff[even_addr] <= cell_ff[even_addr] & even_data;
        cell_ff[even_addr | 13'h0001] <= cell_ff[even_addr | 13'h0001] & op.data;
      end else begin
        cell_ff[op.addr] <= cell_ff[op.addr] & op.data;
      end
    end
    rd_data <= cell_ff[rd_addr];
  end
endmodule : flash_array

// file: hw/flash_key_write_erase_ctrl.sv
// flash key lock, write and erase sequencer behind an apb slave
// What this block does
// - programming only clears bits to zero
// - operations hardware timed, core stalled meanwhile
// - key codes first then second, any delay
// - wrong key value or order disables until reset
// - write before unlock disables until reset
// - lock rearms on every flash write, as the write is taken
// - write enable routes data moves to flash
// - write enable cleared only by software
// - erase sets whole 512 byte page to ff
// - erase: both enables, keys, one write
// - block select picks byte or pair programming
// - pair program takes single byte duration
// - byte mode programs after each flash write
// - pair mode programs after odd address write
// - key register reads lock state low bits
// - erase ignores the written data byte
`timescale 1ns/100ps
`include "flash_ctrl_defs.svh"
module flash_key_write_erase_ctrl
  import flash_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic core_stall,
  output logic xram_write,
  output logic [12:0] xram_addr,
  output logic [7:0] xram_data
);
  // --------------------------------
  // decode helpers
  // --------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction : hit

  localparam logic [7:0] PROG_N = 8'(`PROG_CYCLES);
  localparam logic [7:0] ERASE_N = 8'(`ERASE_CYCLES);

  lock_state_t lock_ff;
  seq_state_t seq_ff;
  flash_op_t op_ff;
  logic write_en_ff;
  logic erase_en_ff;
  logic block_sel_ff;
  logic [7:0] even_ff;
  logic even_seen_ff;
  logic [7:0] timer_ff;
  logic [12:0] rd_addr_ff;
  logic [7:0] array_rd;
  logic wr_access;
  logic rd_access;
  logic key_wr;
  logic move_wr;
  logic flash_move;
  logic start_op;
  logic op_go;
  logic op_done;
  logic mapped;

  // --------------------------------
  // apb access decode
  // --------------------------------
  // a write is taken only in the access phase; the bus waits while an operation runs
  assign pready = (seq_ff == SEQ_IDLE);
  assign wr_access = psel && penable && pwrite && pready;
  assign rd_access = psel && penable && !pwrite && pready;
  assign mapped = hit(paddr, `OFS_STORE_CTRL) || hit(paddr, `OFS_FLASH_KEY) ||
                  hit(paddr, `OFS_PREFETCH_CTRL) || hit(paddr, `OFS_XDATA_WRITE) ||
                  hit(paddr, `OFS_FLASH_DATA);
  assign pslverr = psel && penable && !mapped;
  assign key_wr = wr_access && hit(paddr, `OFS_FLASH_KEY);
  assign move_wr = wr_access && hit(paddr, `OFS_XDATA_WRITE);
  assign flash_move = move_wr && write_en_ff;
  assign core_stall = (seq_ff != SEQ_IDLE);

  // --------------------------------
  // control registers
  // --------------------------------
  // enables change only by software writes, never by an operation
  always_ff @(posedge clk) begin
    if (reset) begin
      write_en_ff <= 1'b0;
      erase_en_ff <= 1'b0;
    end else if (wr_access && hit(paddr, `OFS_STORE_CTRL)) begin
      write_en_ff <= pwdata[`BIT_WRITE_EN];
      erase_en_ff <= pwdata[`BIT_ERASE_EN];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      block_sel_ff <= 1'b0;
    end else if (wr_access && hit(paddr, `OFS_PREFETCH_CTRL)) begin
      block_sel_ff <= pwdata[`BIT_BLOCK_SEL];
    end
  end

  // --------------------------------
  // key lock
  // --------------------------------
  // dead state is sticky: only reset leaves it
  always_ff @(posedge clk) begin
    if (reset) begin
      lock_ff <= KEY_LOCKED;
    end else if (lock_ff == KEY_DEAD) begin
      lock_ff <= KEY_DEAD;
    end else if (key_wr) begin
      unique case (lock_ff)
        KEY_LOCKED: begin
          lock_ff <= (pwdata[7:0] == `KEY_FIRST) ? KEY_FIRST_OK : KEY_DEAD;
        end
        KEY_FIRST_OK: begin
          lock_ff <= (pwdata[7:0] == `KEY_SECOND) ? KEY_OPEN : KEY_DEAD;
        end
        default: begin
          lock_ff <= KEY_DEAD; // extra key write while open
        end
      endcase
    end else if (flash_move) begin
      // any flash write rearms the lock, or kills it if not open
      lock_ff <= (lock_ff == KEY_OPEN) ? KEY_LOCKED : KEY_DEAD;
    end
  end

  // --------------------------------
  // operation start
  // --------------------------------
  // an odd write in pair mode launches; an even write only buffers its byte
  assign start_op = flash_move && (lock_ff == KEY_OPEN) &&
                    (erase_en_ff || !block_sel_ff || pwdata[8] == 1'b0 ?
                     (erase_en_ff || !block_sel_ff) : 1'b1);

  always_ff @(posedge clk) begin
    if (reset) begin
      even_ff <= `ERASED_BYTE;
      even_seen_ff <= 1'b0;
    end else if (flash_move && lock_ff == KEY_OPEN && block_sel_ff && !erase_en_ff &&
                 !pwdata[8]) begin
      even_ff <= pwdata[7:0]; // even half of the pair, normal data lane
      even_seen_ff <= 1'b1;
    end else if (op_done) begin
      even_seen_ff <= 1'b0;
      even_ff <= `ERASED_BYTE;
    end
  end

  // move writes carry the address in pwdata[20:8] and the data in pwdata[7:0]; the even
  // byte of a pair uses the same data lane; the bits pwdata[31:21] above the address go unused
  always_ff @(posedge clk) begin
    if (reset) begin
      op_ff <= '0;
    end else if (start_op) begin
      op_ff.addr <= pwdata[20:8];
      op_ff.data <= pwdata[7:0];
      op_ff.erase <= erase_en_ff;
      op_ff.pair <= block_sel_ff && !erase_en_ff;
    end
  end

  // --------------------------------
  // sequencer
  // --------------------------------
  // pair and byte programs share one duration
  always_ff @(posedge clk) begin
    if (reset) begin
      seq_ff <= SEQ_IDLE;
      timer_ff <= 8'h00;
    end else begin
      unique case (seq_ff)
        SEQ_IDLE: begin
          if (start_op) begin
            seq_ff <= erase_en_ff ? SEQ_ERASE : SEQ_PROG;
            timer_ff <= erase_en_ff ? ERASE_N : PROG_N;
          end
        end
        SEQ_PROG, SEQ_ERASE: begin
          timer_ff <= timer_ff - 8'h01;
          if (timer_ff == 8'h01) begin
            seq_ff <= SEQ_IDLE;
          end
        end
        default: begin
          seq_ff <= SEQ_IDLE;
        end
      endcase
    end
  end

  assign op_done = (seq_ff != SEQ_IDLE) && (timer_ff == 8'h01);
  assign op_go = op_done; // cells change as the operation finishes

  // --------------------------------
  // external ram path and flash read pointer
  // --------------------------------
  // with the write enable clear the data move goes to external ram
  always_ff @(posedge clk) begin
    if (reset) begin
      xram_write <= 1'b0;
      xram_addr <= 13'h0000;
      xram_data <= 8'h00;
    end else begin
      xram_write <= move_wr && !write_en_ff;
      if (move_wr && !write_en_ff) begin
        xram_addr <= pwdata[20:8];
        xram_data <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_addr_ff <= 13'h0000;
    end else if (wr_access && hit(paddr, `OFS_FLASH_DATA)) begin
      rd_addr_ff <= pwdata[12:0];
    end
  end

  flash_array u_array (
    .clk(clk),
    .op_go(op_go),
    .op(op_ff),
    .even_data(even_ff),
    .rd_addr(rd_addr_ff),
    .rd_data(array_rd)
  );

  // --------------------------------
  // read mux
  // --------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (1'b1)
        hit(paddr, `OFS_STORE_CTRL): prdata <= {30'h0, erase_en_ff, write_en_ff};
        hit(paddr, `OFS_FLASH_KEY): prdata <= {30'h0, lock_ff};
        hit(paddr, `OFS_PREFETCH_CTRL): prdata <= {31'h0, block_sel_ff};
        hit(paddr, `OFS_FLASH_DATA): prdata <= {even_seen_ff, 10'h0, rd_addr_ff, array_rd};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // --------------------------------
  // checks
  // --------------------------------
  sequence key_pair_s;
    key_wr && pwdata[7:0] == `KEY_FIRST && lock_ff == KEY_LOCKED;
  endsequence

  // second half of the key: only meaningful once the first code has been taken
  sequence key_second_s;
    key_wr && lock_ff == KEY_FIRST_OK;
  endsequence

  // an operation has ended when the sequencer falls back to idle
  sequence op_end_s;
    seq_ff != SEQ_IDLE ##1 seq_ff == SEQ_IDLE;
  endsequence

  // helper: cycles spent in the current operation; a counter, since the erase span is
  // far longer than a repetition may count
  logic [7:0] stall_len_ff;

  always_ff @(posedge clk) begin
    if (reset) begin
      stall_len_ff <= 8'h00;
    end else if (core_stall) begin
      stall_len_ff <= stall_len_ff + 8'h01;
    end else begin
      stall_len_ff <= 8'h00;
    end
  end

  // lock checks
  dead_sticky_a: assert property (@(posedge clk) disable iff (reset)
    lock_ff == KEY_DEAD |=> lock_ff == KEY_DEAD)
    else $error("disabled lock left without reset");
  first_key_a: assert property (@(posedge clk) disable iff (reset)
    key_pair_s |=> lock_ff == KEY_FIRST_OK)
    else $error("first key not accepted");
  second_key_a: assert property (@(posedge clk) disable iff (reset)
    key_second_s and pwdata[7:0] == `KEY_SECOND |=> lock_ff == KEY_OPEN)
    else $error("second key not accepted");
  bad_key_a: assert property (@(posedge clk) disable iff (reset)
    key_wr && lock_ff == KEY_LOCKED && pwdata[7:0] != `KEY_FIRST |=> lock_ff == KEY_DEAD)
    else $error("wrong key did not disable");
  bad_second_a: assert property (@(posedge clk) disable iff (reset)
    key_second_s and pwdata[7:0] != `KEY_SECOND |=> lock_ff == KEY_DEAD)
    else $error("wrong second key did not disable");
  early_write_a: assert property (@(posedge clk) disable iff (reset)
    flash_move && lock_ff != KEY_OPEN |=> lock_ff == KEY_DEAD && seq_ff == SEQ_IDLE)
    else $error("write while locked not punished");
  rearm_lock_a: assert property (@(posedge clk) disable iff (reset)
    start_op |=> lock_ff == KEY_LOCKED)
    else $error("lock not rearmed");
  op_end_lock_a: assert property (@(posedge clk) disable iff (reset)
    op_end_s |-> lock_ff == KEY_LOCKED)
    else $error("lock open after an operation");

  // operation checks
  stall_span_a: assert property (@(posedge clk) disable iff (reset)
    start_op && !erase_en_ff |=> core_stall [*8] ##1 !core_stall)
    else $error("program duration wrong");
  erase_span_a: assert property (@(posedge clk) disable iff (reset)
    seq_ff == SEQ_ERASE && timer_ff == 8'h01 |-> stall_len_ff == ERASE_N - 8'h01)
    else $error("erase duration wrong");
  enable_hold_a: assert property (@(posedge clk) disable iff (reset)
    op_done |=> $stable(write_en_ff))
    else $error("write enable changed by operation");
  even_no_start_a: assert property (@(posedge clk) disable iff (reset)
    flash_move && block_sel_ff && !erase_en_ff && !pwdata[8] |-> !start_op)
    else $error("even write launched a pair program");
  odd_launch_a: assert property (@(posedge clk) disable iff (reset)
    flash_move && lock_ff == KEY_OPEN && block_sel_ff && !erase_en_ff &&
    pwdata[8] |-> start_op)
    else $error("odd write did not launch a pair program");
  locked_no_op_a: assert property (@(posedge clk) disable iff (reset)
    flash_move && lock_ff != KEY_OPEN |-> !start_op)
    else $error("write while locked started an operation");
  erase_start_a: assert property (@(posedge clk) disable iff (reset)
    start_op && erase_en_ff |=> seq_ff == SEQ_ERASE && op_ff.erase && !op_ff.pair)
    else $error("erase write did not start an erase");
  prog_start_a: assert property (@(posedge clk) disable iff (reset)
    start_op && !erase_en_ff |=> seq_ff == SEQ_PROG && op_ff.pair == block_sel_ff)
    else $error("program kind does not follow block select");

  // routing and read checks
  xram_route_a: assert property (@(posedge clk) disable iff (reset)
    move_wr && !write_en_ff |=> xram_write && xram_addr == $past(pwdata[20:8]))
    else $error("data move not sent to external ram");
  flash_route_a: assert property (@(posedge clk) disable iff (reset)
    flash_move |=> !xram_write)
    else $error("flash write leaked to external ram");
  key_read_a: assert property (@(posedge clk) disable iff (reset)
    psel && !penable && !pwrite && hit(paddr, `OFS_FLASH_KEY) |=>
    prdata == {30'h0, $past(lock_ff)})
    else $error("key register read wrong lock state");
endmodule : flash_key_write_erase_ctrl

// file: bench/xram_model.sv
// external ram stand-in that records data moves routed away from flash
`timescale 1ns/100ps
module xram_model (
  input wire logic clk,
  input wire logic xram_write,
  input wire logic [12:0] xram_addr,
  input wire logic [7:0] xram_data,
  output logic [20:0] last_ff
);
  // keeps only the last move: the bench checks each move right after it
  always_ff @(posedge clk) begin
    if (xram_write === 1'b1) begin
      last_ff <= {xram_addr, xram_data};
    end
  end
endmodule : xram_model

// file: bench/flash_key_write_erase_ctrl_test.sv
// self-checking bench for the flash key, write and erase controller
`timescale 1ns/100ps
`include "flash_ctrl_defs.svh"
module flash_key_write_erase_ctrl_test
  import flash_ctrl_pkg::*;
;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, core_stall, xram_write, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [12:0] xram_addr;
  logic [7:0] xram_data;
  logic [20:0] last_ff;
  int num_errors = 0;
  int n_tests = 0;
  int n;

  flash_key_write_erase_ctrl uut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_stall(core_stall), .xram_write(xram_write),
    .xram_addr(xram_addr), .xram_data(xram_data));
  xram_model ram (.clk(clk), .xram_write(xram_write), .xram_addr(xram_addr),
    .xram_data(xram_data), .last_ff(last_ff));

  // 200 mhz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----------
  // report
  // ----------
  task automatic print_verdict;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  task automatic hang;
    num_errors++;
    print_verdict();
  endtask : hang

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // ----------
  // bus tasks
  // ----------
  // request held until pready is seen high; a stalled operation just lengthens the wait
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 300; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 300) hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // counts stall cycles after the taking edge of a data move
  task automatic mv(input logic [12:0] a, input logic [7:0] d);
    apb(1'b1, `OFS_XDATA_WRITE, {11'h000, a, d});
    n = 0;
    repeat (200) begin
      #1;
      if (core_stall !== 1'b1) return;
      n++;
      @(posedge clk);
    end
    hang();
  endtask : mv

  task automatic keys;
    apb(1'b1, `OFS_FLASH_KEY, 32'(`KEY_FIRST));
    apb(1'b1, `OFS_FLASH_KEY, 32'(`KEY_SECOND));
  endtask : keys

  task automatic key_is(input lock_state_t s);
    apb(1'b0, `OFS_FLASH_KEY, 32'h0000_0000);
    chk(32'(rd[1:0]), 32'(s));
  endtask : key_is

  task automatic fl(input logic [12:0] a, input logic [7:0] exp);
    apb(1'b1, `OFS_FLASH_DATA, 32'(a));
    apb(1'b0, `OFS_FLASH_DATA, 32'h0000_0000);
    chk(32'(rd[7:0]), 32'(exp));
  endtask : fl

  task automatic do_reset;
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
  endtask : do_reset

  // ----------
  // sequence
  // ----------
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    key_is(KEY_LOCKED);
    // page erase with a junk data byte
    apb(1'b1, `OFS_STORE_CTRL, 32'h0000_0003);
    keys();
    mv(13'h0005, 8'h12);
    chk(n, `ERASE_CYCLES);
    apb(1'b1, `OFS_STORE_CTRL, 32'h0000_0001);
    fl(13'h0000, `ERASED_BYTE);
    fl(13'h01FF, `ERASED_BYTE);
    fl(13'h0005, `ERASED_BYTE);
    key_is(KEY_LOCKED);
    // byte mode, then a second program over the same byte
    apb(1'b1, `OFS_FLASH_KEY, 32'(`KEY_FIRST));
    key_is(KEY_FIRST_OK);
    apb(1'b1, `OFS_FLASH_KEY, 32'(`KEY_SECOND));
    key_is(KEY_OPEN);
    mv(13'h0010, 8'h5A);
    chk(n, `PROG_CYCLES);
    keys();
    mv(13'h0010, 8'hF0);
    fl(13'h0010, 8'h50);
    apb(1'b0, `OFS_STORE_CTRL, 32'h0000_0000);
    chk(32'(rd[1:0]), 32'h0000_0001);
    // pair mode: even byte waits, odd byte launches; the even write rearms the lock
    apb(1'b1, `OFS_PREFETCH_CTRL, 32'h0000_0001);
    keys();
    mv(13'h0120, 8'h60);
    chk(n, 0);
    key_is(KEY_LOCKED);
    keys();
    mv(13'h0121, 8'hC3);
    chk(n, `PROG_CYCLES);
    fl(13'h0120, 8'h60);
    fl(13'h0121, 8'hC3);
    fl(13'h0122, `ERASED_BYTE);
    // second pass over the block: ff leaves the even byte as it is
    keys();
    mv(13'h0120, `ERASED_BYTE);
    keys();
    mv(13'h0121, 8'h81);
    fl(13'h0120, 8'h60);
    fl(13'h0121, 8'h81);
    // write enable clear: moves go to external ram
    apb(1'b1, `OFS_PREFETCH_CTRL, 32'h0000_0000);
    apb(1'b1, `OFS_STORE_CTRL, 32'h0000_0000);
    mv(13'h0123, 8'hA7);
    // the pulse comes on the edge that takes the move and the model records it one edge later
    repeat (2) @(posedge clk);
    #1;
    chk(32'(last_ff), {11'h000, 13'h0123, 8'hA7});
    fl(13'h0123, `ERASED_BYTE);
    // wrong key value, then an attempt while dead
    apb(1'b1, `OFS_FLASH_KEY, 32'h0000_0000);
    key_is(KEY_DEAD);
    apb(1'b1, `OFS_STORE_CTRL, 32'h0000_0001);
    mv(13'h0030, 8'h00);
    chk(n, 0);
    fl(13'h0030, `ERASED_BYTE);
    // codes out of order
    do_reset();
    apb(1'b1, `OFS_FLASH_KEY, 32'(`KEY_SECOND));
    key_is(KEY_DEAD);
    // right first code, wrong second code
    do_reset();
    apb(1'b1, `OFS_FLASH_KEY, 32'(`KEY_FIRST));
    apb(1'b1, `OFS_FLASH_KEY, 32'h0000_0000);
    key_is(KEY_DEAD);
    // flash write with no keys at all
    do_reset();
    apb(1'b1, `OFS_STORE_CTRL, 32'h0000_0001);
    mv(13'h0031, 8'h00);
    key_is(KEY_DEAD);
    fl(13'h0031, `ERASED_BYTE);
    // unmapped offset answers with an error
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    print_verdict();
  end
endmodule : flash_key_write_erase_ctrl_test
